//--- bench/test_tmsi_top.sv
`include "tmsi_defines.vh"
// Drives the block through the host model and the status pins.
module test_tmsi_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        txdis = 1'b1;
    logic        lflt = 1'b0;
    logic        sd = 1'b0;
    logic        rxd = 1'b0;
    logic        scl;
    logic        sda_h;
    logic        sda_o;
    logic        sda_oe;
    logic        pres;
    logic        tx_en;
    logic        tx_flt;
    logic        lost;
    logic        rxd_o;
    logic [15:0] mon [5];
    logic [7:0]  wb [8];
    logic [7:0]  rb [10];
    int          error_cnt = 0;
    int          checked = 0;
    wire         sda = sda_h & (~sda_oe | sda_o);

    tmsi_top tmsi_top_inst (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_mgmt_clock_pin(scl), .i_mgmt_data_pin(sda),
        .o_mgmt_data_pin_o(sda_o), .o_mgmt_data_pin_oe(sda_oe),
        .o_presence_pin(pres), .i_tx_disable(txdis),
        .i_laser_fault(lflt), .o_tx_enable(tx_en),
        .o_tx_fault(tx_flt), .i_signal_detect(sd),
        .i_rx_data(rxd), .o_rx_signal_lost(lost), .o_rx_data(rxd_o),
        .i_temp(mon[0]), .i_bias(mon[1]), .i_tx_power(mon[2]),
        .i_rx_power(mon[3]), .i_vcc(mon[4])
    );
    tmsi_host tmsi_host_inst (
        .i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda(sda_h)
    );
    // Free-running 50 MHz system clock.
    initial forever #10 i_mclk = ~i_mclk;

    task automatic tick(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e,
                       input string what);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: %s %h not %h", $time, what, g, e);
        end
    endtask
    // Pointer write followed by n data bytes.
    task automatic wr(input logic [6:0] a, input logic [7:0] p,
                      input int n, input logic ack);
        logic r;
        tmsi_host_inst.start();
        tmsi_host_inst.put({a, 1'b0}, r);
        chk(r, ack, "address ack");
        if (r) begin
            tmsi_host_inst.put(p, r);
            for (int i = 0; i < n; i++) begin
                tmsi_host_inst.put(wb[i], r);
                chk(r, 1'b1, "data ack");
            end
        end
        tmsi_host_inst.stop();
    endtask
    // Pointer write, repeated start, then n sequential reads.
    task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n);
        logic r;
        tmsi_host_inst.start();
        tmsi_host_inst.put({a, 1'b0}, r);
        tmsi_host_inst.put(p, r);
        tmsi_host_inst.start();
        tmsi_host_inst.put({a, 1'b1}, r);
        for (int i = 0; i < n; i++) tmsi_host_inst.get(i == n - 1, rb[i]);
        tmsi_host_inst.stop();
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence.
    initial begin
        mon = '{16'h1234, 16'h0345, 16'h2456, 16'h1567, 16'h8678};
        tick(6);
        chk(pres, 1'b0, "presence");
        chk(lost, 1'b1, "lost in reset");
        i_rst_n = 1'b1;
        tick(4);
        wb[0] = 8'ha5;
        wb[1] = 8'h3c;
        wr(`TMSI_ID_ADDR, 8'h80, 2, 1'b1);
        wb[0] = 8'h55;
        wr(`TMSI_DIAG_ADDR, 8'h80, 1, 1'b1);
        rd(`TMSI_ID_ADDR, 8'h80, 2);
        chk(rb[0], 8'ha5, "id byte");
        chk(rb[1], 8'h3c, "id next");
        rd(`TMSI_DIAG_ADDR, 8'h80, 1);
        chk(rb[0], 8'h55, "diag byte");
        wr(7'h52, 8'h00, 0, 1'b0);
        // Temperature limits: alarm 1000/0100, warning 0800/0200.
        wb = '{8'h10, 8'h00, 8'h01, 8'h00, 8'h08, 8'h00, 8'h02, 8'h00};
        wr(`TMSI_DIAG_ADDR, 8'h00, 8, 1'b1);
        tick(`TMSI_REFRESH_CYC + 60);
        rd(`TMSI_DIAG_ADDR, `TMSI_DIAG_VAL_BASE, 10);
        for (int k = 0; k < 10; k++)
            chk(rb[k], mon[k / 2] >> (k[0] ? 0 : 8), "live");
        wb[0] = 8'h00;
        wr(`TMSI_DIAG_ADDR, `TMSI_DIAG_VAL_BASE, 1, 1'b1);
        rd(`TMSI_DIAG_ADDR, `TMSI_DIAG_VAL_BASE, 1);
        chk(rb[0], mon[0][15:8], "protected");
        // Above the high limits, below the low ones, then in range.
        for (int k = 0; k < 3; k++) begin
            mon[0] = k == 0 ? 16'h1234 : (k == 1 ? 16'h0050 : 16'h0400);
            tick(`TMSI_REFRESH_CYC + 60);
            rd(`TMSI_DIAG_ADDR, `TMSI_DIAG_ALM_OFS, 5);
            chk(rb[0] & 8'h03, 8'h02 >> k, "alarm");
            chk(rb[4] & 8'h03, 8'h02 >> k, "warning");
        end
        // Transmit, fault and receive status pins.
        txdis = 1'b0;
        tick(5);
        chk(tx_en, 1'b1, "tx on");
        txdis = 1'b1;
        tick(`TMSI_TXDIS_CYC);
        chk(tx_en, 1'b0, "tx off");
        lflt = 1'b1;
        tick(5);
        chk(tx_flt, 1'b1, "fault");
        lflt = 1'b0;
        sd = 1'b1;
        tick(5);
        chk(tx_flt, 1'b0, "no fault");
        chk(lost, 1'b0, "signal");
        for (int k = 0; k < 4; k++) begin
            rxd = k[0];
            tick(3);
            chk(rxd_o, rxd, "rx data");
        end
        sd = 1'b0;
        tick(5);
        chk(lost, 1'b1, "no signal");
        conclude();
    end
endmodule // test_tmsi_top

//--- bench/tmsi_chk_assertions.sv
// Watches the status pins and the data-line driver of the block.
module tmsi_chk (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Watched pins
    input wire logic i_mgmt_clock_pin,
    input wire logic o_mgmt_data_pin_o,
    input wire logic o_mgmt_data_pin_oe,
    input wire logic o_presence_pin,
    input wire logic i_tx_disable,
    input wire logic i_laser_fault,
    input wire logic o_tx_enable,
    input wire logic o_tx_fault,
    input wire logic i_signal_detect,
    input wire logic i_rx_data,
    input wire logic o_rx_signal_lost,
    input wire logic o_rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TXDIS_MAX = 500;
    // Every check samples on the system clock and sleeps in reset.
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    // Presence stays low; transmitter control and fault follow their inputs.
    a_presence_low: assert property (!o_presence_pin)
        else $error("presence pin not low");
    a_tx_off: assert property (i_tx_disable[*5] |-> !o_tx_enable)
        else $error("transmitter on while disabled");
    a_tx_on: assert property
        ((!i_tx_disable && !i_laser_fault)[*5] |-> o_tx_enable)
        else $error("transmitter off while enabled");
    a_tx_deadline: assert property
        ($rose(i_tx_disable) |-> ##[1:TXDIS_MAX] !o_tx_enable)
        else $error("transmitter not off in time");
    a_fault_set: assert property (i_laser_fault[*5] |-> o_tx_fault)
        else $error("fault not reported");
    a_fault_clear: assert property
        ((!i_laser_fault)[*5] |-> !o_tx_fault)
        else $error("fault reported without cause");
    // Receive status and gated receive data.
    a_los_set: assert property
        ((!i_signal_detect)[*5] |-> o_rx_signal_lost && !o_rx_data)
        else $error("loss of signal not shown");
    a_los_clear: assert property
        (i_signal_detect[*5] |-> !o_rx_signal_lost)
        else $error("loss of signal shown with signal");
    a_rx_pass: assert property
        (i_signal_detect[*5] |-> o_rx_data == $past(i_rx_data, 3))
        else $error("receive data not passed");
    // The data line only changes while the serial clock is low.
    a_sda_launch: assert property
        (($changed(o_mgmt_data_pin_oe) || o_mgmt_data_pin_oe &&
          $changed(o_mgmt_data_pin_o)) |-> !i_mgmt_clock_pin)
        else $error("data line changed with clock high");
endmodule // tmsi_chk

bind tmsi_top tmsi_chk tmsi_chk_inst (.*);

//--- bench/tmsi_host.sv
// Host controller that masters the two-wire bus at 160 ns per bit.
module tmsi_host (
    // Clock
    input  wire logic i_mclk,
    // Two-wire lines
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus: both lines released high, clock stands still.
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // One bit: data set mid-low, sampled late in the high phase.
    task automatic bit_io(input logic b, output logic r);
        hold(2);
        o_sda = b;
        hold(2);
        o_scl = 1'b1;
        hold(4);
        r = i_sda;
        o_scl = 1'b0;
    endtask
    // Start, also usable as a repeated start.
    task automatic start();
        hold(2);
        o_sda = 1'b1;
        hold(2);
        o_scl = 1'b1;
        hold(4);
        o_sda = 1'b0;
        hold(4);
        o_scl = 1'b0;
    endtask
    task automatic stop();
        hold(2);
        o_sda = 1'b0;
        hold(2);
        o_scl = 1'b1;
        hold(4);
        o_sda = 1'b1;
        hold(4);
    endtask
    // Whole bytes, most significant bit first, then the ack bit.
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            d = {d[6:0], r};
        end
        bit_io(last, r);
    endtask
endmodule // tmsi_host

//--- rtl/tmsi_defines.vh
`ifndef TMSI_DEFINES_VH
`define TMSI_DEFINES_VH

// Seven-bit bus addresses of the identification and diagnostic maps.
`define TMSI_ID_ADDR        7'h50
`define TMSI_DIAG_ADDR      7'h51

// Size of each map in bytes and its address width.
`define TMSI_MAP_BYTES      256
`define TMSI_MAP_AW         8

// Identification map: bytes below this offset are write-protected.
`define TMSI_ID_WP_LIMIT    8'h80

// Diagnostic map layout: thresholds, live values, flags, user area.
`define TMSI_DIAG_THR_END   8'h28
`define TMSI_DIAG_VAL_BASE  8'h60
`define TMSI_DIAG_ALM_OFS   8'h70
`define TMSI_DIAG_WRN_OFS   8'h74
`define TMSI_DIAG_USER_BASE 8'h80

// Number of monitored quantities.
`define TMSI_NUM_MON        5

// Transmit-disable deadline, in ns, and the cycle count at 20 ns.
`define TMSI_CLK_NS         20
`define TMSI_TXDIS_NS       10000
`define TMSI_TXDIS_CYC      (`TMSI_TXDIS_NS / `TMSI_CLK_NS)

// Last refresh count; the diagnostic sample is taken every 1024 cycles.
`define TMSI_REFRESH_CYC    16'h03ff

// Refresh count at which samples and flags are written to the map.
`define TMSI_REFRESH_WR     16'h0001

`endif

//--- rtl/tmsi_mon_chk.v
`include "tmsi_defines.vh"

// Compares one 16-bit monitored value against its four thresholds.
module tmsi_mon_chk (
    // Sample and limits
    input  wire [15:0] i_value,
    input  wire [15:0] i_alm_hi,
    input  wire [15:0] i_alm_lo,
    input  wire [15:0] i_wrn_hi,
    input  wire [15:0] i_wrn_lo,
    // Flags
    output wire [1:0]  o_alm,
    output wire [1:0]  o_wrn
);

    // High flag in bit 1, low flag in bit 0.
    assign o_alm = {i_value > i_alm_hi, i_value < i_alm_lo};
    assign o_wrn = {i_value > i_wrn_hi, i_value < i_wrn_lo};

endmodule // tmsi_mon_chk

//--- rtl/tmsi_top.v
`include "tmsi_defines.vh"

// Summary of operation
// - Answer bus address 1010000X with a 256-byte identification map.
// - Answer address 1010001X with the diagnostic map; identification map unchanged.
// - Capture data on rising clock; store only into unprotected locations.
// - Launch read data after the falling clock edge, driving the data line.
// - Maps are byte-wide, accessed singly or sequentially with auto-increment.
// - Report temperature, bias, transmit power, receive power and supply.
// - Set alarm and warning flags when a value other than supply leaves its range; supply flags are dropped.
// - Diagnostic values are delivered already calibrated.
// - Loss-of-signal output is 0 in normal reception, 1 without signal.
// - Pass recovered receive data while loss-of-signal is deasserted.
// - Shut off transmitter within 10 us of transmit-disable assertion.
// - Transmitter off while disable is high or open, on only when low.
// - Transmit-fault output high on laser fault, low otherwise.
// - Presence pin held permanently grounded.
module tmsi_top (
    // Clock and reset
    input  wire        i_mclk,
    input  wire        i_rst_n,
    // Management serial pins
    input  wire        i_mgmt_clock_pin,
    input  wire        i_mgmt_data_pin,
    output reg         o_mgmt_data_pin_o,
    output reg         o_mgmt_data_pin_oe,
    output reg         o_presence_pin,
    // Transmit control and status
    input  wire        i_tx_disable,
    input  wire        i_laser_fault,
    output reg         o_tx_enable,
    output reg         o_tx_fault,
    // Receive path
    input  wire        i_signal_detect,
    input  wire        i_rx_data,
    output reg         o_rx_signal_lost,
    output reg         o_rx_data,
    // Calibrated monitor inputs
    input  wire [15:0] i_temp,
    input  wire [15:0] i_bias,
    input  wire [15:0] i_tx_power,
    input  wire [15:0] i_rx_power,
    input  wire [15:0] i_vcc
);

    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_WRX  = 3'h3;
    localparam ST_WACK = 3'h4;
    localparam ST_RTX  = 3'h5;
    localparam ST_RACK = 3'h6;

    // Both memories, declared here.
    reg  [7:0]  id_mem   [0:`TMSI_MAP_BYTES-1];
    reg  [7:0]  diag_mem [0:`TMSI_MAP_BYTES-1];

    reg  [2:0]  scl_sync_reg;
    reg  [2:0]  sda_sync_reg;
    reg  [1:0]  txd_sync_reg;
    reg  [1:0]  los_sync_reg;
    reg  [1:0]  flt_sync_reg;
    reg  [1:0]  rxd_sync_reg;
    reg  [2:0]  state_reg;
    reg  [3:0]  bit_cnt_reg;
    reg  [7:0]  shift_reg;
    reg         diag_sel_reg;
    reg         rd_reg;
    reg         ptr_loaded_reg;
    reg  [7:0]  ptr_reg;
    reg  [15:0] refresh_cnt_reg;
    reg  [15:0] sample_reg [0:`TMSI_NUM_MON-1];
    reg  [7:0]  alm_reg;
    reg  [7:0]  wrn_reg;
    reg  [7:0]  rd_byte;
    wire [9:0]  alm_raw;
    wire [9:0]  wrn_raw;
    wire        scl_rise;
    wire        scl_fall;
    wire        sda_s;
    wire        scl_s;
    wire        start_det;
    wire        stop_det;
    wire        wr_prot;
    wire [15:0] mon_in [0:`TMSI_NUM_MON-1];
    integer     k;
    integer     j;

    assign mon_in[0] = i_temp;
    assign mon_in[1] = i_bias;
    assign mon_in[2] = i_tx_power;
    assign mon_in[3] = i_rx_power;
    assign mon_in[4] = i_vcc;

    // Synchronisers; stage 1 feeds stage 2 only, edges use stages 2 and 3.
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            txd_sync_reg <= 2'h3;
            los_sync_reg <= 2'h0;
            flt_sync_reg <= 2'h0;
            rxd_sync_reg <= 2'h0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], i_mgmt_clock_pin};
            sda_sync_reg <= {sda_sync_reg[1:0], i_mgmt_data_pin};
            txd_sync_reg <= {txd_sync_reg[0], i_tx_disable};
            los_sync_reg <= {los_sync_reg[0], i_signal_detect};
            flt_sync_reg <= {flt_sync_reg[0], i_laser_fault};
            rxd_sync_reg <= {rxd_sync_reg[0], i_rx_data};
        end
    end

    assign scl_s     = scl_sync_reg[1];
    assign sda_s     = sda_sync_reg[1];
    assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
    assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
    // Data moving while the clock is high frames a transaction.
    assign start_det = scl_s & scl_sync_reg[2] & ~sda_s
                       & sda_sync_reg[2];
    assign stop_det  = scl_s & scl_sync_reg[2] & sda_s
                       & ~sda_sync_reg[2];
    // Lower identification half and diagnostic bytes from threshold end up to the user area are read-only.
    assign wr_prot   = diag_sel_reg
                       ? ((ptr_reg < `TMSI_DIAG_USER_BASE)
                          && (ptr_reg >= `TMSI_DIAG_THR_END))
                       : (ptr_reg < `TMSI_ID_WP_LIMIT);

    // Read byte selects the map addressed by the device address.
    always @* begin
        if (diag_sel_reg)
            rd_byte = diag_mem[ptr_reg];
        else
            rd_byte = id_mem[ptr_reg];
    end

    // Serial slave: address, pointer, data and acknowledge phases.
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg          <= ST_IDLE;
            bit_cnt_reg        <= 4'h0;
            shift_reg          <= 8'h00;
            diag_sel_reg       <= 1'b0;
            rd_reg             <= 1'b0;
            ptr_loaded_reg     <= 1'b0;
            ptr_reg            <= 8'h00;
            o_mgmt_data_pin_o  <= 1'b0;
            o_mgmt_data_pin_oe <= 1'b0;
        end else if (stop_det) begin
            state_reg          <= ST_IDLE;
            o_mgmt_data_pin_oe <= 1'b0;
        end else if (start_det) begin
            state_reg          <= ST_ADDR;
            bit_cnt_reg        <= 4'h0;
            o_mgmt_data_pin_oe <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    o_mgmt_data_pin_oe <= 1'b0;
                end
                ST_ADDR, ST_WRX: begin
                    if (scl_fall)
                        o_mgmt_data_pin_oe <= 1'b0;
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    if (scl_fall && bit_cnt_reg == 4'h8) begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == ST_ADDR) begin
                            if (shift_reg[7:1] == `TMSI_ID_ADDR
                                || shift_reg[7:1] == `TMSI_DIAG_ADDR) begin
                                diag_sel_reg <= shift_reg[1];
                                rd_reg       <= shift_reg[0];
                                ptr_loaded_reg <= 1'b0;
                                o_mgmt_data_pin_o  <= 1'b0;
                                o_mgmt_data_pin_oe <= 1'b1;
                                state_reg    <= ST_AACK;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end else begin
                            if (!ptr_loaded_reg) begin
                                ptr_reg        <= shift_reg;
                                ptr_loaded_reg <= 1'b1;
                            end else begin
                                if (!wr_prot) begin
                                    if (diag_sel_reg)
                                        diag_mem[ptr_reg] <= shift_reg;
                                    else
                                        id_mem[ptr_reg] <= shift_reg;
                                end
                                ptr_reg <= ptr_reg + 8'h01;
                            end
                            o_mgmt_data_pin_o  <= 1'b0;
                            o_mgmt_data_pin_oe <= 1'b1;
                            state_reg          <= ST_WACK;
                        end
                    end
                end
                ST_AACK, ST_WACK: begin
                    if (scl_fall) begin
                        if (rd_reg && state_reg == ST_AACK) begin
                            o_mgmt_data_pin_o  <= rd_byte[7];
                            o_mgmt_data_pin_oe <= 1'b1;
                            shift_reg   <= {rd_byte[6:0], 1'b0};
                            bit_cnt_reg <= 4'h1;
                            state_reg   <= ST_RTX;
                        end else begin
                            o_mgmt_data_pin_oe <= 1'b0;
                            state_reg <= ST_WRX;
                        end
                    end
                end
                ST_RTX: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == 4'h8) begin
                            o_mgmt_data_pin_oe <= 1'b0;
                            ptr_reg   <= ptr_reg + 8'h01;
                            state_reg <= ST_RACK;
                        end else begin
                            o_mgmt_data_pin_o <= shift_reg[7];
                            shift_reg   <= {shift_reg[6:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    // Host acknowledge low continues, high ends the read.
                    if (scl_rise)
                        rd_reg <= ~sda_s;
                    if (scl_fall) begin
                        if (rd_reg) begin
                            o_mgmt_data_pin_o  <= rd_byte[7];
                            o_mgmt_data_pin_oe <= 1'b1;
                            shift_reg   <= {rd_byte[6:0], 1'b0};
                            bit_cnt_reg <= 4'h1;
                            state_reg   <= ST_RTX;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
        // Refresh copies samples and flags into the map two cycles after
        // sampling, so the flags already reflect the new samples.
        if (i_rst_n && refresh_cnt_reg == `TMSI_REFRESH_WR) begin
            for (k = 0; k < `TMSI_NUM_MON; k = k + 1) begin
                diag_mem[`TMSI_DIAG_VAL_BASE + 2*k]     <= sample_reg[k][15:8];
                diag_mem[`TMSI_DIAG_VAL_BASE + 2*k + 1] <= sample_reg[k][7:0];
            end
            diag_mem[`TMSI_DIAG_ALM_OFS] <= alm_reg;
            diag_mem[`TMSI_DIAG_WRN_OFS] <= wrn_reg;
        end
    end

    // Threshold comparators, one per monitored quantity.
    genvar g;
    generate
        for (g = 0; g < `TMSI_NUM_MON; g = g + 1) begin : g_chk
            tmsi_mon_chk u_chk (
                .i_value  (sample_reg[g]),
                .i_alm_hi ({diag_mem[8*g],     diag_mem[8*g+1]}),
                .i_alm_lo ({diag_mem[8*g+2],   diag_mem[8*g+3]}),
                .i_wrn_hi ({diag_mem[8*g+4],   diag_mem[8*g+5]}),
                .i_wrn_lo ({diag_mem[8*g+6],   diag_mem[8*g+7]}),
                .o_alm    (alm_raw[2*g+1:2*g]),
                .o_wrn    (wrn_raw[2*g+1:2*g])
            );
        end
    endgenerate

    // Periodic sampler of calibrated inputs and flag summary.
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            refresh_cnt_reg <= 16'h0000;
            alm_reg         <= 8'h00;
            wrn_reg         <= 8'h00;
            for (j = 0; j < `TMSI_NUM_MON; j = j + 1)
                sample_reg[j] <= 16'h0000;
        end else begin
            if (refresh_cnt_reg == `TMSI_REFRESH_CYC) begin
                refresh_cnt_reg <= 16'h0000;
                for (j = 0; j < `TMSI_NUM_MON; j = j + 1)
                    sample_reg[j] <= mon_in[j];
            end else begin
                refresh_cnt_reg <= refresh_cnt_reg + 16'h0001;
            end
            alm_reg <= {alm_raw[7:0]};
            wrn_reg <= {wrn_raw[7:0]};
        end
    end

    // Pin status outputs.
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_enable      <= 1'b0;
            o_tx_fault       <= 1'b0;
            o_rx_signal_lost <= 1'b1;
            o_rx_data        <= 1'b0;
            o_presence_pin   <= 1'b0;
        end else begin
            // Low input enables; high or open disables within 3 cycles.
            o_tx_enable      <= ~txd_sync_reg[1];
            o_tx_fault       <= flt_sync_reg[1];
            o_rx_signal_lost <= ~los_sync_reg[1];
            o_rx_data        <= los_sync_reg[1] & rxd_sync_reg[1];
            o_presence_pin   <= 1'b0;
        end
    end

endmodule // tmsi_top
